// *** bus_decode_pkg.sv ***
// Behaviour
// - Host bits 9:8: 00 runtime, 01 controller-only, 11 config, 10 DMA.
// - Host address bits 23:10 come from the device map, not raw I/O.
// - A host device is a 1KB frame of four 256-byte regions; 64 at most.
// - Runtime cycles use the lowest 256 bytes; config portal the top 256.
// - DMA FIFO offsets 200h-2FFh are unused; legacy DMA goes to the units.
// - Controller frames are flat 1KB windows, maybe eight 128-byte blocks.
// - Controller requests outside data memory and both bridges get an error.
// - In-range accesses to no assigned logical device get an error.
// - Accesses to unimplemented offsets in a present device get an error.
// - Peripheral bus: byte addressed, 16-bit space, 32-bit data, aligned.
// - Byte accesses are never merged; one master access is one transfer.
// - A peripheral transfer takes two cycles; an AHB access three in all.
// - Peripheral bus carries word address, four strobes, 64 one-hot selects.
// - Peripherals steer register bytes to lanes by the active strobes.
// - Host bridge decodes from FF_0000h, controller from F0_0000h; 64KB each.
// - Word registers are word aligned; byte and halfword accesses work too.
// - Read-only registers ignore writes; write-only registers read zero.
// - Clear-on-one bits clear on 1, hold on 0; a hardware set wins.
// - Set-on-one bits set on 1 and hold on 0.
// - Reserved fields read zero, ignore writes; software writes them as zero.
package bus_decode_pkg;

  localparam int FRAME_BYTES = 1024;
  localparam int REGION_BYTES = 256;
  localparam int MAX_LDN = 64;
  localparam int INST_BYTES = 128;
  localparam int INST_PER_FRAME = 8;
  localparam int PBUS_CYCLES = 2;

  localparam int PAGE_LSB = 16;
  localparam int LDN_MSB = 15;
  localparam int LDN_LSB = 10;
  localparam int RGN_MSB = 9;
  localparam int RGN_LSB = 8;
  localparam int INST_MSB = 9;
  localparam int INST_LSB = 7;
  localparam int WORD_MSB = 9;
  localparam int WORD_LSB = 2;

  localparam logic [1:0] RGN_RUNTIME = 2'h0;
  localparam logic [1:0] RGN_EC_ONLY = 2'h1;
  localparam logic [1:0] RGN_DMA = 2'h2;
  localparam logic [1:0] RGN_CONFIG = 2'h3;

  localparam logic [7:0] HOST_PERIPH_PAGE = 8'hFF;
  localparam logic [7:0] EC_PERIPH_PAGE = 8'hF0;
  localparam logic [7:0] A2A_PAGE_LO = 8'hFD;

  localparam logic [15:0] CFG_INDEX_PORT = 16'h002E;
  localparam logic [15:0] CFG_DATA_PORT = 16'h002F;
  localparam logic [9:0] DMA_FIFO_LO = 10'h200;
  localparam logic [9:0] DMA_FIFO_HI = 10'h2FF;
  localparam logic [5:0] LDN_PARALLEL = 6'h11;
  localparam logic [5:0] LDN_FLOPPY = 6'h0B;

  localparam logic [63:0] HOST_LD_DEFAULT = 64'h8000_0000_0002_9D83;
  localparam logic [63:0] EC_LD_DEFAULT = 64'h800F_0008_0F40_026A;

  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [1:0] HRESP_ERROR = 2'h1;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [3:0] STRB_BYTE0 = 4'h1;
  localparam logic [3:0] STRB_LOW_HALF = 4'h3;
  localparam logic [3:0] STRB_HIGH_HALF = 4'hC;
  localparam logic [3:0] STRB_WORD = 4'hF;

  typedef enum logic [1:0] {ACC_RUNTIME, ACC_CONFIG, ACC_DMA} host_access_t;

  typedef struct packed {
    logic [7:0] word_addr;
    logic [3:0] strb;
    logic write;
    logic [2:0] inst;
  } pbus_cmd_t;

endpackage : bus_decode_pkg

// *** host_address_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_address_map
  import bus_decode_pkg::*;
#(
  parameter logic [63:0] LD_PRESENT = HOST_LD_DEFAULT
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic map_valid,
  input wire host_access_t map_kind,
  input wire logic [5:0] map_ldn,
  input wire logic [7:0] map_offset,
  output logic map_done,
  output logic map_hit,
  output logic map_direct,
  output logic [23:0] map_addr
);

  logic [1:0] rgn;

  always_comb
  begin
    unique case (map_kind)
      ACC_RUNTIME: rgn = RGN_RUNTIME;
      ACC_CONFIG: rgn = RGN_CONFIG;
      ACC_DMA: rgn = RGN_DMA;
      default: rgn = RGN_DMA;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      map_done <= 1'b0;
      map_hit <= 1'b0;
      map_direct <= 1'b0;
      map_addr <= '0;
    end
    else
    begin
      map_done <= map_valid;
      if (map_valid)
      begin
        // The DMA FIFO region is never claimed on this part.
        map_hit <= LD_PRESENT[map_ldn] && (map_kind != ACC_DMA);
        map_direct <= (map_kind == ACC_DMA) &&
                      ((map_ldn == LDN_PARALLEL) || (map_ldn == LDN_FLOPPY));
        map_addr <= {HOST_PERIPH_PAGE, map_ldn, rgn, map_offset};
      end
    end
  end

  a_region_code: assert property (@(posedge ref_clk) disable iff (rst)
    map_valid && map_kind == ACC_CONFIG |=> map_addr[9:8] == RGN_CONFIG)
    else $error("config access not placed in top region");

  a_frame_fill: assert property (@(posedge ref_clk) disable iff (rst)
    map_valid |=> map_addr[23:10] == {HOST_PERIPH_PAGE, $past(map_ldn)})
    else $error("frame bits not taken from device map");

  a_dma_unused: assert property (@(posedge ref_clk) disable iff (rst)
    map_valid && map_kind == ACC_DMA |=> map_done && !map_hit)
    else $error("dma fifo region claimed");

endmodule : host_address_map
`default_nettype wire

// *** pbus_peripheral_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbus_peripheral_model
  import bus_decode_pkg::*;
#(
  parameter logic [7:0] BAD_WORD = 8'hFF
)
(
  input wire logic ref_clk,
  input wire logic pbus_req,
  input wire logic pbus_commit,
  input wire pbus_cmd_t pbus_cmd,
  input wire logic [31:0] pbus_wdata,
  output logic [31:0] pbus_rdata,
  output logic pbus_err
);
  logic [31:0] mem [256];
  logic [31:0] last_q;
  // Outside a transfer the read bus flips every cycle, so a stale word
  // can never pass for a fresh one.
  always_comb
  begin
    pbus_rdata = pbus_req ? mem[pbus_cmd.word_addr] : ~last_q;
    pbus_err = pbus_req && (pbus_cmd.word_addr == BAD_WORD);
  end
  always @(posedge ref_clk)
  begin
    last_q <= pbus_rdata;
    if (pbus_commit === 1'b1)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (pbus_cmd.strb[i])
          mem[pbus_cmd.word_addr][8*i +: 8] <= pbus_wdata[8*i +: 8];
      end
    end
  end
  initial
  begin
    last_q = 32'h0;
    for (int i = 0; i < 256; i++)
      mem[i] = 32'h0;
  end
endmodule : pbus_peripheral_model
`default_nettype wire

// *** peripheral_bus_address_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module peripheral_bus_address_decode
  import bus_decode_pkg::*;
#(
  parameter logic [23:0] DCCM_LO = 24'h00_0000,
  parameter logic [23:0] DCCM_HI = 24'h00_3FFF,
  parameter logic [63:0] HOST_LD_PRESENT = HOST_LD_DEFAULT,
  parameter logic [63:0] EC_LD_PRESENT = EC_LD_DEFAULT
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [23:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hmaster_host,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  output logic dccm_sel,
  output logic a2a_sel,
  input wire logic map_valid,
  input wire host_access_t map_kind,
  input wire logic [5:0] map_ldn,
  input wire logic [7:0] map_offset,
  output logic map_done,
  output logic map_hit,
  output logic map_direct,
  output logic [23:0] map_addr,
  output pbus_cmd_t pbus_cmd,
  output logic [31:0] pbus_wdata,
  output logic [63:0] host_ld_sel,
  output logic [63:0] ec_ld_sel,
  output logic pbus_req,
  output logic pbus_commit,
  input wire logic [31:0] pbus_rdata,
  input wire logic pbus_err
);

  typedef enum logic [2:0] {ST_IDLE, ST_XFER, ST_DONE, ST_ERR1, ST_ERR2}
    state_t;

  state_t state_q;
  state_t state_d;

  logic acc_take;
  logic [7:0] page;
  logic [5:0] ldn;
  logic [1:0] rgn;
  logic size_bad;
  logic misaligned;
  logic hit_host;
  logic hit_ec;
  logic in_dccm;
  logic in_a2a;
  logic ld_ok;
  logic host_rgn_bad;
  logic go_bridge;
  logic go_err;
  logic [3:0] strb;
  logic write_q;
  logic err_q;
  pbus_cmd_t cmd_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [63:0] host_sel_q;
  logic [63:0] ec_sel_q;

  function automatic logic [3:0] lane_strobe(input logic [2:0] size,
                                             input logic [1:0] low);
    logic [3:0] s;
    s = 4'h0;
    case (size)
      HSIZE_BYTE: s = STRB_BYTE0 << low;
      HSIZE_HALF: s = low[1] ? STRB_HIGH_HALF : STRB_LOW_HALF;
      HSIZE_WORD: s = STRB_WORD;
      default: s = 4'h0;
    endcase
    return s;
  endfunction : lane_strobe

  host_address_map #(
    .LD_PRESENT(HOST_LD_PRESENT)
  ) u_host_map (
    .ref_clk(ref_clk),
    .rst(rst),
    .map_valid(map_valid),
    .map_kind(map_kind),
    .map_ldn(map_ldn),
    .map_offset(map_offset),
    .map_done(map_done),
    .map_hit(map_hit),
    .map_direct(map_direct),
    .map_addr(map_addr)
  );

  always_comb
  begin
    acc_take = hsel && hready && (htrans[1] != HTRANS_IDLE[1]);
    page = haddr[23:PAGE_LSB];
    ldn = haddr[LDN_MSB:LDN_LSB];
    rgn = haddr[RGN_MSB:RGN_LSB];
    // Unaligned or oversized transfers are refused, not split.
    size_bad = (hsize > HSIZE_WORD);
    misaligned = size_bad ||
                 ((hsize == HSIZE_HALF) && haddr[0]) ||
                 ((hsize == HSIZE_WORD) && (haddr[1:0] != 2'h0));
    // The host can never reach the controller window.
    hit_host = hmaster_host && (page == HOST_PERIPH_PAGE);
    hit_ec = !hmaster_host && (page == EC_PERIPH_PAGE);
    in_dccm = !hmaster_host && (haddr >= DCCM_LO) && (haddr <= DCCM_HI);
    in_a2a = !hmaster_host && !in_dccm && (page >= A2A_PAGE_LO);
    ld_ok = hit_host ? HOST_LD_PRESENT[ldn] : EC_LD_PRESENT[ldn];
    // Controller-only and DMA FIFO regions have no host path.
    host_rgn_bad = hit_host && ((rgn == RGN_EC_ONLY) || (rgn == RGN_DMA));
    go_bridge = acc_take && (hit_host || hit_ec) && ld_ok &&
                !misaligned && !host_rgn_bad;
    go_err = acc_take && !in_dccm && !in_a2a && !go_bridge;
    strb = lane_strobe(hsize, haddr[1:0]);
  end

  assign dccm_sel = hsel && in_dccm;
  assign a2a_sel = hsel && in_a2a;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE, ST_DONE, ST_ERR2:
      begin
        if (go_bridge)
          state_d = ST_XFER;
        else if (go_err)
          state_d = ST_ERR1;
        else
          state_d = ST_IDLE;
      end
      ST_XFER: state_d = ST_DONE;
      ST_ERR1: state_d = ST_ERR2;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Each accepted access loads exactly one command; nothing is merged.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cmd_q <= '0;
      write_q <= 1'b0;
    end
    else if (go_bridge)
    begin
      cmd_q.word_addr <= haddr[WORD_MSB:WORD_LSB];
      cmd_q.strb <= strb;
      cmd_q.write <= hwrite;
      cmd_q.inst <= hit_ec ? haddr[INST_MSB:INST_LSB] : 3'h0;
      write_q <= hwrite;
    end
  end

  // Selects stand for the two peripheral cycles and drop afterwards.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      host_sel_q <= '0;
      ec_sel_q <= '0;
    end
    else if (go_bridge)
    begin
      host_sel_q <= hit_host ? (64'h1 << ldn) : '0;
      ec_sel_q <= hit_ec ? (64'h1 << ldn) : '0;
    end
    else if (state_q != ST_XFER)
    begin
      host_sel_q <= '0;
      ec_sel_q <= '0;
    end
  end

  // Write data arrives in the AHB data phase, one cycle after the address.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wdata_q <= '0;
    else if (state_q == ST_XFER && write_q)
      wdata_q <= hwdata;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rdata_q <= '0;
      err_q <= 1'b0;
    end
    else if (state_q == ST_XFER)
    begin
      err_q <= pbus_err;
      rdata_q <= (!write_q && !pbus_err) ? pbus_rdata : '0;
    end
    else if (go_err)
    begin
      rdata_q <= '0;
    end
  end

  assign pbus_cmd = cmd_q;
  assign pbus_wdata = wdata_q;
  assign host_ld_sel = host_sel_q;
  assign ec_ld_sel = ec_sel_q;
  assign hrdata = rdata_q;
  assign pbus_req = (state_q == ST_XFER) || (state_q == ST_DONE);
  // A write commits only once the peripheral has accepted its offset.
  assign pbus_commit = (state_q == ST_DONE) && write_q && !err_q;

  always_comb
  begin
    hreadyout = 1'b1;
    hresp = HRESP_OKAY;
    unique case (state_q)
      ST_IDLE:
      begin
        hreadyout = 1'b1;
        hresp = HRESP_OKAY;
      end
      ST_XFER:
      begin
        hreadyout = 1'b0;
        hresp = pbus_err ? HRESP_ERROR : HRESP_OKAY;
      end
      ST_DONE:
      begin
        hreadyout = 1'b1;
        hresp = err_q ? HRESP_ERROR : HRESP_OKAY;
      end
      ST_ERR1:
      begin
        hreadyout = 1'b0;
        hresp = HRESP_ERROR;
      end
      ST_ERR2:
      begin
        hreadyout = 1'b1;
        hresp = HRESP_ERROR;
      end
    endcase
  end

  a_xfer_three_cycles: assert property (@(posedge ref_clk)
    disable iff (rst)
    go_bridge |=> !hreadyout ##1 hreadyout)
    else $error("bridge access not three cycles");

  a_req_two_cycles: assert property (@(posedge ref_clk)
    disable iff (rst)
    go_bridge |=> pbus_req [*2])
    else $error("peripheral transfer not two cycles");

  a_error_shape: assert property (@(posedge ref_clk) disable iff (rst)
    go_err |=> (hresp == HRESP_ERROR && !hreadyout)
           ##1 (hresp == HRESP_ERROR && hreadyout))
    else $error("error response not two cycles");

  a_err_no_commit: assert property (@(posedge ref_clk) disable iff (rst)
    hresp == HRESP_ERROR |-> !pbus_commit)
    else $error("write committed during error");

  a_sel_onehot: assert property (@(posedge ref_clk) disable iff (rst)
    $onehot0({host_ld_sel, ec_ld_sel}) && (pbus_req || !(|host_ld_sel)))
    else $error("device select not one-hot");

  a_one_commit: assert property (@(posedge ref_clk) disable iff (rst)
    pbus_commit |=> !pbus_commit)
    else $error("one access gave two commits");

  a_unmapped_ld: assert property (@(posedge ref_clk) disable iff (rst)
    acc_take && (hit_host || hit_ec) && !ld_ok |=>
      hresp == HRESP_ERROR && !hreadyout && !pbus_req)
    else $error("absent device not refused");

  a_ec_outside: assert property (@(posedge ref_clk) disable iff (rst)
    acc_take && !hmaster_host && !in_dccm && !in_a2a && !hit_ec |=>
      hresp == HRESP_ERROR && !hreadyout)
    else $error("controller request outside ranges not refused");

  a_bad_offset: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_XFER && pbus_err |=>
      hresp == HRESP_ERROR && hreadyout && !pbus_commit)
    else $error("invalid offset not refused");

  a_word_strobe: assert property (@(posedge ref_clk) disable iff (rst)
    go_bridge && hsize == HSIZE_WORD |=>
      pbus_cmd.strb == STRB_WORD && pbus_cmd.word_addr == $past(haddr[9:2]))
    else $error("word transfer strobes wrong");

endmodule : peripheral_bus_address_decode
`default_nettype wire

// *** reg_field.sv ***
`timescale 1ns/1ps
`default_nettype none
module reg_field
  import bus_decode_pkg::*;
#(
  parameter int W = 32,
  parameter logic [W-1:0] RESET = '0,
  parameter logic [W-1:0] RO_MASK = '0,
  parameter logic [W-1:0] WO_MASK = '0,
  parameter logic [W-1:0] W1C_MASK = '0,
  parameter logic [W-1:0] W1S_MASK = '0,
  parameter logic [W-1:0] RSVD_MASK = '0
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [3:0] wr_strb,
  input wire logic [31:0] wr_data,
  input wire logic [W-1:0] hw_set,
  input wire logic [W-1:0] hw_value,
  output logic [31:0] rd_data,
  output logic [W-1:0] value_q
);

  logic [31:0] lane_mask;
  logic [W-1:0] we;
  logic [W-1:0] wbits;
  logic [W-1:0] rw_mask;
  logic [W-1:0] value_d;

  // Only strobed lanes move, so part-word writes work.
  assign lane_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                      {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign we = wr_en ? lane_mask[W-1:0] : '0;
  assign wbits = we & wr_data[W-1:0];
  assign rw_mask = ~(RO_MASK | W1C_MASK | W1S_MASK | RSVD_MASK);

  always_comb
  begin
    value_d = (rw_mask & (wbits | (value_q & ~we)))
            | (W1C_MASK & ((value_q & ~wbits) | hw_set))
            | (W1S_MASK & (value_q | wbits))
            | (RO_MASK & hw_value);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      value_q <= RESET & ~RSVD_MASK;
    else
      value_q <= value_d;
  end

  // Write-only bits keep their value inside but never show it.
  assign rd_data = 32'(value_q & ~WO_MASK & ~RSVD_MASK);

  a_w1c_set_wins: assert property (@(posedge ref_clk)
    disable iff (rst)
    |(hw_set & W1C_MASK) |=>
      (value_q & $past(hw_set) & W1C_MASK) == ($past(hw_set) & W1C_MASK))
    else $error("hardware set lost to software clear");

  a_ro_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    wr_en |=> (value_q & RO_MASK) == ($past(hw_value) & RO_MASK))
    else $error("write changed a read-only bit");

  a_w1s_holds: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ($past(value_q) & W1S_MASK & ~value_q) == '0)
    else $error("set-on-one bit fell");

endmodule : reg_field
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
  import bus_decode_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [23:0] haddr = 24'h0;
  logic [1:0] htrans = HTRANS_IDLE;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_BYTE;
  logic [31:0] hwdata = 32'h0;
  logic host = 1'b0;
  logic map_valid = 1'b0;
  host_access_t map_kind = ACC_RUNTIME;
  logic [5:0] map_ldn = 6'h0;
  logic [7:0] map_offset = 8'h0;
  logic hreadyout, dccm_sel, a2a_sel, pbus_req, pbus_commit, pbus_err;
  logic map_done, map_hit, map_direct;
  logic [1:0] hresp;
  logic [31:0] hrdata, pbus_wdata, pbus_rdata;
  logic [23:0] map_addr;
  logic [63:0] host_ld_sel, ec_ld_sel;
  pbus_cmd_t pbus_cmd;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [1:0] r1, rsp;
  logic [31:0] rdv;
  logic [63:0] sel;
  logic rdy1, com;
  pbus_cmd_t cmd;
  int cyc;
  logic wr_en = 1'b0;
  logic [3:0] wr_strb = 4'h0;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] hw_set = 32'h0;
  logic [31:0] hw_value = 32'h0000_A500;
  logic [31:0] rd_data, field_value;

  always #12.5 ref_clk = ~ref_clk;

  peripheral_bus_address_decode dut (.ref_clk, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hmaster_host(host), .hreadyout, .hresp, .hrdata, .dccm_sel,
    .a2a_sel, .map_valid, .map_kind, .map_ldn, .map_offset, .map_done,
    .map_hit, .map_direct, .map_addr, .pbus_cmd, .pbus_wdata,
    .host_ld_sel, .ec_ld_sel, .pbus_req, .pbus_commit, .pbus_rdata,
    .pbus_err);

  pbus_peripheral_model peri (.ref_clk, .pbus_req, .pbus_commit,
    .pbus_cmd, .pbus_wdata, .pbus_rdata, .pbus_err);

  // One field of every access kind, so each register rule is exercised.
  reg_field #(
    .W(32),
    .RESET(32'hC0F0_0000),
    .RO_MASK(32'h0000_FF00),
    .WO_MASK(32'h3000_0000),
    .W1C_MASK(32'h00FF_0000),
    .W1S_MASK(32'h0F00_0000),
    .RSVD_MASK(32'hC000_0000)
  ) fld (.ref_clk, .rst, .wr_en, .wr_strb, .wr_data, .hw_set, .hw_value,
    .rd_data, .value_q(field_value));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // The next address phase starts in the response cycle, so every pair of
  // calls also exercises back-to-back acceptance.
  task automatic ahb(input logic [23:0] a, input logic w,
    input logic [2:0] sz, input logic [31:0] d, input logic h);
    hsel = 1'b1;
    haddr = a;
    hwrite = w;
    hsize = sz;
    host = h;
    htrans = 2'h2;
    @(posedge ref_clk);
    #1;
    hsel = 1'b0;
    htrans = HTRANS_IDLE;
    hwdata = d;
    r1 = hresp;
    rdy1 = hreadyout;
    sel = host_ld_sel | ec_ld_sel;
    cmd = pbus_cmd;
    com = pbus_commit;
    cyc = 1;
    do
    begin
      @(posedge ref_clk);
      #1;
      cyc++;
    end
    while (hreadyout !== 1'b1 && cyc < 20);
    rsp = hresp;
    rdv = hrdata;
    com = com | pbus_commit;
  endtask : ahb

  task automatic xfer(input logic [23:0] a, input logic w,
    input logic [2:0] sz, input logic [31:0] d, input logic h,
    input logic [1:0] er, input logic [31:0] erd, input logic [31:0] m);
    ahb(a, w, sz, d, h);
    chk(cyc, 2);
    chk({rdy1, r1, rsp}, {1'b0, er, er});
    chk(com, w && er == HRESP_OKAY);
    if (!w && er == HRESP_OKAY)
      chk(rdv & m, erd);
  endtask : xfer

  task automatic t_reset;
    chk({hreadyout, hresp, pbus_req, pbus_commit, map_done}, 6'h20);
    chk(hrdata, 32'h0);
    chk(host_ld_sel | ec_ld_sel, 64'h0);
  endtask : t_reset

  task automatic t_ctl;
    xfer(24'hF0_0404, 1, HSIZE_WORD, 32'h3C5A_96E1, 0, 0, 0, 0);
    chk(sel, 64'h2);
    chk(cmd, {8'h01, STRB_WORD, 1'b1, 3'h0});
    xfer(24'hF0_0405, 1, HSIZE_BYTE, 32'h7700, 0, 0, 0, 0);
    chk(cmd.strb, 4'h2);
    xfer(24'hF0_0406, 1, HSIZE_HALF, 32'h1234_0000, 0, 0, 0, 0);
    chk(cmd.strb, STRB_HIGH_HALF);
    xfer(24'hF0_0404, 0, HSIZE_WORD, 0, 0, 0, 32'h1234_77E1, '1);
    xfer(24'hF0_0407, 0, HSIZE_BYTE, 0, 0, 0, 32'h1200_0000,
      32'hFF00_0000);
    xfer(24'hF0_0780, 1, HSIZE_WORD, 32'h5A5A_0001, 0, 0, 0, 0);
    chk({cmd.inst, cmd.word_addr}, {3'h7, 8'hE0});
  endtask : t_ctl

  task automatic t_host;
    xfer(24'hFF_2811, 1, HSIZE_BYTE, 32'hAB00, 1, 0, 0, 0);
    chk(sel, 64'h400);
    chk({cmd.inst, cmd.strb}, {3'h0, 4'h2});
    xfer(24'hFF_2811, 0, HSIZE_BYTE, 0, 1, 0, 32'hAB00, 32'hFF00);
    xfer(24'hFF_2B01, 1, HSIZE_BYTE, 32'h0C00, 1, 0, 0, 0);
    chk(cmd.word_addr, 8'hC0);
  endtask : t_host

  task automatic t_err;
    xfer(24'hF0_0400, 1, HSIZE_BYTE, 32'hFF, 1, 1, 0, 0);
    chk(sel, 64'h0);
    xfer(24'hF0_0008, 1, HSIZE_WORD, '1, 0, 1, 0, 0);
    xfer(24'hFF_0800, 1, HSIZE_BYTE, '1, 1, 1, 0, 0);
    xfer(24'hF0_0406, 1, HSIZE_WORD, '1, 0, 1, 0, 0);
    xfer(24'hF0_0404, 1, 3'h3, '1, 0, 1, 0, 0);
    xfer(24'h80_0000, 0, HSIZE_WORD, 0, 0, 1, 0, 0);
    xfer(24'hFF_2900, 1, HSIZE_BYTE, '1, 1, 1, 0, 0);
    xfer(24'hFF_2A00, 0, HSIZE_BYTE, 0, 1, 1, 0, 0);
    xfer(24'hF0_07FC, 1, HSIZE_WORD, '1, 0, 1, 0, 0);
    chk(sel, 64'h2);
    xfer(24'hF0_0404, 0, HSIZE_WORD, 0, 0, 0, 32'h1234_77E1, '1);
  endtask : t_err

  task automatic side(input logic [23:0] a, input logic [1:0] ex);
    hsel = 1'b1;
    haddr = a;
    host = 1'b0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    htrans = 2'h2;
    #1;
    chk({dccm_sel, a2a_sel}, ex);
    @(posedge ref_clk);
    #1;
    hsel = 1'b0;
    htrans = HTRANS_IDLE;
    chk({hreadyout, hresp, pbus_req}, 4'h8);
    @(posedge ref_clk);
    #1;
  endtask : side

  task automatic mp(input host_access_t k, input logic [5:0] l,
    input logic [7:0] o, input logic [23:0] ea, input logic [1:0] hd);
    map_valid = 1'b1;
    map_kind = k;
    map_ldn = l;
    map_offset = o;
    @(posedge ref_clk);
    #1;
    map_valid = 1'b0;
    chk({map_done, map_hit, map_direct, map_addr}, {1'b1, hd, ea});
    @(posedge ref_clk);
    #1;
    chk(map_done, 1'b0);
  endtask : mp

  task automatic t_map;
    mp(ACC_RUNTIME, 6'h0A, 8'h05, 24'hFF_2805, 2'h2);
    mp(ACC_CONFIG, 6'h0A, 8'h05, 24'hFF_2B05, 2'h2);
    mp(ACC_DMA, 6'h11, 8'h10, 24'hFF_4610, 2'h1);
    mp(ACC_DMA, 6'h0B, 8'h10, 24'hFF_2E10, 2'h1);
    mp(ACC_DMA, 6'h0A, 8'h10, 24'hFF_2A10, 2'h0);
    mp(ACC_RUNTIME, 6'h02, 8'h05, 24'hFF_0805, 2'h0);
    mp(ACC_CONFIG, 6'h3F, 8'hFF, 24'hFF_FFFF, 2'h2);
  endtask : t_map

  // One strobed write with a hardware set beside it, then an idle edge.
  task automatic fw(input logic [3:0] s, input logic [31:0] d,
    input logic [31:0] hs, input logic [31:0] hv);
    wr_en = 1'b1;
    wr_strb = s;
    wr_data = d;
    hw_set = hs;
    hw_value = hv;
    @(posedge ref_clk);
    #1;
    wr_en = 1'b0;
    hw_set = 32'h0;
    @(posedge ref_clk);
    #1;
  endtask : fw

  task automatic t_reg;
    chk(rd_data, 32'h00F0_A500);
    fw(STRB_WORD, 32'hFFFF_FFFF, 32'h0, 32'h0000_A500);
    chk(rd_data, 32'h0F00_A5FF);
    chk(field_value, 32'h3F00_A5FF);
    fw(4'hC, 32'h0001_0000, 32'h0003_0000, 32'h0000_A500);
    chk(rd_data, 32'h0F03_A5FF);
    fw(4'h4, 32'h0003_0000, 32'h0, 32'h0000_5A00);
    chk(rd_data, 32'h0F00_5AFF);
  endtask : t_reg

  initial
  begin
    #100000;
    n_mismatch++;
    final_report();
  end

  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_ctl();
    t_host();
    t_err();
    side(24'h00_0100, 2'h2);
    side(24'hFD_0000, 2'h1);
    t_map();
    t_reg();
    final_report();
  end
endmodule : tb
`default_nettype wire
